// ==== core/synth_cfg_params.svh ====
`ifndef SYNTH_CFG_PARAMS_SVH
`define SYNTH_CFG_PARAMS_SVH

// ----------------------------------------------------------------------------
// word layout
// ----------------------------------------------------------------------------
`define CFG_WORD_W        24
`define ADDR_W            4
`define DATA_LSB          4

// low address bits of each word (word 0 is any code with bit 0 clear)
`define ADDR_W0_BIT       0
`define ADDR_W1           4'h3
`define ADDR_W2           4'h5
`define ADDR_ACCESS       4'h7
`define ADDR_MODE         4'h9
`define ADDR_FRAC_EXT     4'hB
`define ADDR_FASTLOCK     4'hD
`define ADDR_TEST_RESET   4'hF

// ----------------------------------------------------------------------------
// access word fields
// ----------------------------------------------------------------------------
`define ACCESS_LSB        20
`define ACCESS_MUST_BIT   20
`define GAIN_LSB          16
`define AUX_R_LSB         4

// ----------------------------------------------------------------------------
// mode word fields
// ----------------------------------------------------------------------------
`define AUTOPU_BIT        23
`define FIXED_MSB         22
`define FIXED_LSB         18
`define FIXED_VAL         5'h08
`define DITHER_LSB        16
`define ORDER_LSB         14
`define ZERO_BIT          13
`define DOUBLER_BIT       12
`define OSCOUT_BIT        11
`define AUX_POL_BIT       10
`define MAIN_POL_BIT      9
`define PRESC_BIT         8
`define MUX_LSB           4

// ----------------------------------------------------------------------------
// reset and default contents
// ----------------------------------------------------------------------------
`define ACCESS_RESET      24'h100007
`define MODE_RESET        24'h22C709
`define FRAC_EXT_DEFAULT  24'h00000B
`define FASTLOCK_DEFAULT  24'h00000D
`define TEST_RST_DEFAULT  24'h00090F

// ----------------------------------------------------------------------------
// test/lock pin select codes
// ----------------------------------------------------------------------------
`define SEL_HIZ           4'h0
`define SEL_HIGH          4'h1
`define SEL_LOW           4'h2
`define SEL_DLD_BOTH      4'h3
`define SEL_DLD_MAIN      4'h4
`define SEL_DLD_AUX       4'h5
`define SEL_ALD_BOTH_OD   4'h6
`define SEL_ALD_MAIN_OD   4'h7
`define SEL_ALD_AUX_OD    4'h8
`define SEL_ALD_BOTH      4'h9
`define SEL_ALD_MAIN      4'hA
`define SEL_ALD_AUX       4'hB
`define SEL_DIV_FIRST     4'hC

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define REF_CLK_NS        20
`define SCLK_HALF_NS      40
`define SCLK_HALF_CYC     ((`SCLK_HALF_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

`endif

// ==== core/synth_cfg_pkg.sv ====
`default_nettype none

`include "synth_cfg_params.svh"

package synth_cfg_pkg;

  typedef logic [`CFG_WORD_W-1:0] cfg_word_t;
  typedef logic [`ADDR_W-1:0]     word_addr_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] idx;
  } word_sel_t;

  typedef enum {
    H_IDLE,
    H_SHIFT_LO,
    H_SHIFT_HI,
    H_LATCH
  } host_state_t;

  // maps the low address bits of a word to its number 0..7
  function automatic word_sel_t word_index(input word_addr_t a);
    word_sel_t s;
    s.hit = 1'b1;
    s.idx = 3'h0;
    if (!a[`ADDR_W0_BIT]) begin
      s.idx = 3'h0;
    end else if (a == `ADDR_W1) begin
      s.idx = 3'h1;
    end else if (a == `ADDR_W2) begin
      s.idx = 3'h2;
    end else if (a == `ADDR_ACCESS) begin
      s.idx = 3'h3;
    end else if (a == `ADDR_MODE) begin
      s.idx = 3'h4;
    end else if (a == `ADDR_FRAC_EXT) begin
      s.idx = 3'h5;
    end else if (a == `ADDR_FASTLOCK) begin
      s.idx = 3'h6;
    end else if (a == `ADDR_TEST_RESET) begin
      s.idx = 3'h7;
    end else begin
      s.hit = 1'b0;
    end
    return s;
  endfunction

endpackage

`default_nettype wire

// ==== core/serial_cfg_if.sv ====
`default_nettype none

interface serial_cfg_if;
  logic sclk;
  logic sdata;
  logic latch_en;

  modport host (
    output sclk,
    output sdata,
    output latch_en
  );

  modport dev (
    input sclk,
    input sdata,
    input latch_en
  );
endinterface

`default_nettype wire

// ==== core/shift_word_rx.sv ====
`default_nettype none

`include "synth_cfg_params.svh"

module shift_word_rx
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               sclk,
  input  wire logic               sdata,
  input  wire logic               latch_en,
  output logic                    word_stb,
  output synth_cfg_pkg::cfg_word_t word
);
  import synth_cfg_pkg::*;

  logic      sclk_prev_q;
  logic      le_prev_q;
  cfg_word_t shift_q;
  cfg_word_t shift_d;
  logic      sclk_rise;
  logic      le_rise;

  assign sclk_rise = sclk && !sclk_prev_q && !latch_en;
  assign le_rise   = latch_en && !le_prev_q;
  // msb first: the address nibble is the last to arrive
  assign shift_d   = sclk_rise ? {shift_q[`CFG_WORD_W-2:0], sdata} : shift_q;
  assign word      = shift_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      le_prev_q   <= 1'b0;
      shift_q     <= '0;
      word_stb    <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= sclk;
      le_prev_q   <= latch_en;
      shift_q     <= shift_d;
      word_stb    <= le_rise;
    end
  end

endmodule

`default_nettype wire

// ==== core/synth_cfg_device.sv ====
`default_nettype none

`include "synth_cfg_params.svh"

module synth_cfg_device
(
  input  wire logic           REF_CLK,
  input  wire logic           RST_N,
  input  wire logic           CE,
  serial_cfg_if.dev           LINK,
  input  wire logic           DIG_LOCK_MAIN,
  input  wire logic           DIG_LOCK_AUX,
  input  wire logic           ANA_LOCK_MAIN,
  input  wire logic           ANA_LOCK_AUX,
  input  wire logic           AUX_REF_DIV,
  input  wire logic           AUX_FB_DIV,
  input  wire logic           MAIN_REF_DIV,
  input  wire logic           MAIN_FB_DIV,
  output logic                TEST_LOCK_PIN_O,
  output logic                TEST_LOCK_PIN_OE_N,
  output logic [3:0]          MAIN_PUMP_GAIN,
  output logic [4:0]          MAIN_PUMP_SCALE,
  output logic [3:0]          ACCESS_SELECT,
  output synth_cfg_pkg::cfg_word_t ACCESS_WORD,
  output synth_cfg_pkg::cfg_word_t MODE_WORD,
  output synth_cfg_pkg::cfg_word_t FRACTION_EXT_WORD,
  output synth_cfg_pkg::cfg_word_t FASTLOCK_WORD,
  output synth_cfg_pkg::cfg_word_t TEST_RESET_WORD,
  output logic [4:0]          MANDATORY_LOADED,
  output logic                FORMAT_ERROR
);
  import synth_cfg_pkg::*;

  // --------------------------------------------------------------------------
  // serial word receiver
  // --------------------------------------------------------------------------
  logic      word_stb;
  cfg_word_t rx_word;
  word_sel_t sel;

  shift_word_rx u_rx (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .sclk     (LINK.sclk),
    .sdata    (LINK.sdata),
    .latch_en (LINK.latch_en),
    .word_stb (word_stb),
    .word     (rx_word)
  );

  assign sel = word_index(rx_word[`ADDR_W-1:0]);

  logic wr_access;
  logic wr_mode;
  assign wr_access = word_stb && sel.hit && (sel.idx == 3'h3);
  assign wr_mode   = word_stb && sel.hit && (sel.idx == 3'h4);

  // --------------------------------------------------------------------------
  // access word and pump gain
  // --------------------------------------------------------------------------
  logic [4:0] scale_d;
  logic       access_bad;
  logic       mode_bad;

  assign scale_d    = {1'b0, rx_word[`GAIN_LSB+3:`GAIN_LSB]} + 5'h01;
  assign access_bad = !rx_word[`ACCESS_MUST_BIT];
  // fixed pattern and zero bit checked; fields still taken as written
  assign mode_bad   = (rx_word[`FIXED_MSB:`FIXED_LSB] != `FIXED_VAL) || rx_word[`ZERO_BIT];

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ACCESS_WORD     <= `ACCESS_RESET;
      MAIN_PUMP_SCALE <= 5'h01;
      FORMAT_ERROR    <= 1'b0;
    end else if (CE) begin
      if (wr_access) begin
        ACCESS_WORD     <= rx_word;
        MAIN_PUMP_SCALE <= scale_d;
        FORMAT_ERROR    <= access_bad;
      end else if (wr_mode) begin
        FORMAT_ERROR    <= mode_bad;
      end
    end
  end

  assign MAIN_PUMP_GAIN = ACCESS_WORD[`GAIN_LSB+3:`GAIN_LSB];
  assign ACCESS_SELECT  = ACCESS_WORD[`ACCESS_LSB+3:`ACCESS_LSB];

  // --------------------------------------------------------------------------
  // mode word
  // --------------------------------------------------------------------------
  // powers up with the reference settings so the pin mux is defined
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      MODE_WORD <= `MODE_RESET;
    end else if (CE && wr_mode) begin
      MODE_WORD <= rx_word;
    end
  end

  // --------------------------------------------------------------------------
  // optional words: defaults while their access bit is clear
  // --------------------------------------------------------------------------
  localparam cfg_word_t OPT_DEFAULT [3] = '{`FRAC_EXT_DEFAULT, `FASTLOCK_DEFAULT, `TEST_RST_DEFAULT};

  cfg_word_t opt_q [3];

  for (genvar i = 0; i < 3; i++) begin : g_opt
    logic opt_wr;
    assign opt_wr = word_stb && sel.hit && (sel.idx == 3'(5 + i));
    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        opt_q[i] <= OPT_DEFAULT[i];
      end else if (CE) begin
        if (!ACCESS_SELECT[i+1]) begin
          opt_q[i] <= OPT_DEFAULT[i];
        end else if (opt_wr) begin
          opt_q[i] <= rx_word;
        end
      end
    end
  end

  assign FRACTION_EXT_WORD = opt_q[0];
  assign FASTLOCK_WORD     = opt_q[1];
  assign TEST_RESET_WORD   = opt_q[2];

  // --------------------------------------------------------------------------
  // mandatory word bookkeeping
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      MANDATORY_LOADED <= 5'h00;
    end else if (CE && word_stb && sel.hit && (sel.idx < 3'h5)) begin
      MANDATORY_LOADED[sel.idx] <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // divider outputs halved
  // --------------------------------------------------------------------------
  logic [3:0] div_in;
  logic [3:0] div_prev_q;
  logic [3:0] div_half_q;

  // order follows select codes 12..15
  assign div_in = {MAIN_FB_DIV, MAIN_REF_DIV, AUX_FB_DIV, AUX_REF_DIV};

  for (genvar k = 0; k < 4; k++) begin : g_half
    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        div_prev_q[k] <= 1'b0;
        div_half_q[k] <= 1'b0;
      end else if (CE) begin
        div_prev_q[k] <= div_in[k];
        if (div_in[k] && !div_prev_q[k]) begin
          div_half_q[k] <= !div_half_q[k];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // test/lock pin multiplexer
  // --------------------------------------------------------------------------
  logic [3:0] pin_sel;
  logic       dld_both;
  logic       ald_both;
  logic       pin_o_d;
  logic       pin_oe_n_d;

  assign pin_sel  = MODE_WORD[`MUX_LSB+3:`MUX_LSB];
  assign dld_both = DIG_LOCK_MAIN && DIG_LOCK_AUX;
  assign ald_both = ANA_LOCK_MAIN && ANA_LOCK_AUX;

  always_comb begin
    pin_o_d    = 1'b0;
    pin_oe_n_d = 1'b0;
    case (pin_sel)
      `SEL_HIZ:         pin_oe_n_d = 1'b1;
      `SEL_HIGH:        pin_o_d    = 1'b1;
      `SEL_LOW:         pin_o_d    = 1'b0;
      `SEL_DLD_BOTH:    pin_o_d    = dld_both;
      `SEL_DLD_MAIN:    pin_o_d    = DIG_LOCK_MAIN;
      `SEL_DLD_AUX:     pin_o_d    = DIG_LOCK_AUX;
      // open-drain: pull low while unlocked, release once locked
      `SEL_ALD_BOTH_OD: pin_oe_n_d = ald_both;
      `SEL_ALD_MAIN_OD: pin_oe_n_d = ANA_LOCK_MAIN;
      `SEL_ALD_AUX_OD:  pin_oe_n_d = ANA_LOCK_AUX;
      `SEL_ALD_BOTH:    pin_o_d    = ald_both;
      `SEL_ALD_MAIN:    pin_o_d    = ANA_LOCK_MAIN;
      `SEL_ALD_AUX:     pin_o_d    = ANA_LOCK_AUX;
      default:          pin_o_d    = div_half_q[2'(pin_sel - `SEL_DIV_FIRST)];
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      TEST_LOCK_PIN_O    <= 1'b0;
      TEST_LOCK_PIN_OE_N <= 1'b1;
    end else if (CE) begin
      TEST_LOCK_PIN_O    <= pin_o_d;
      TEST_LOCK_PIN_OE_N <= pin_oe_n_d;
    end
  end

endmodule

`default_nettype wire

// ==== core/synth_cfg_host.sv ====
`default_nettype none

`include "synth_cfg_params.svh"

module synth_cfg_host
(
  input  wire logic                REF_CLK,
  input  wire logic                RST_N,
  input  wire logic                CE,
  serial_cfg_if.host               LINK,
  input  wire logic                WRITE_REQ,
  input  wire synth_cfg_pkg::cfg_word_t WRITE_WORD,
  output logic                     BUSY,
  output logic                     WRITE_DONE,
  output logic                     CONFIG_READY
);
  import synth_cfg_pkg::*;

  localparam logic [2:0] HALF_CYC = 3'(`SCLK_HALF_CYC);

  host_state_t state_q;
  cfg_word_t   shift_q;
  logic [4:0]  bits_q;
  logic [2:0]  cnt_q;
  logic        sclk_q;
  logic        sdata_q;
  logic        le_q;
  logic [7:0]  loaded_q;
  logic [2:0]  opt_sel_q;

  // --------------------------------------------------------------------------
  // word shaping before it goes out
  // --------------------------------------------------------------------------
  word_sel_t req_sel;
  cfg_word_t fixed_word;
  logic      half_done;
  logic      opt_ok;
  logic      req_counts;

  assign req_sel   = word_index(WRITE_WORD[`ADDR_W-1:0]);
  assign half_done = (cnt_q == HALF_CYC - 3'h1);

  always_comb begin
    fixed_word = WRITE_WORD;
    if (req_sel.hit && req_sel.idx == 3'h3) begin
      fixed_word[`ACCESS_MUST_BIT] = 1'b1;
    end
    if (req_sel.hit && req_sel.idx == 3'h4) begin
      fixed_word[`FIXED_MSB:`FIXED_LSB] = `FIXED_VAL;
      fixed_word[`ZERO_BIT]             = 1'b0;
      fixed_word[`ADDR_W-1:0]           = `ADDR_MODE;
    end
  end

  // optional words count as ready when left to defaults
  assign opt_ok = &(loaded_q[7:5] | ~opt_sel_q);

  // the device drops an optional word while its access bit is clear, so it only counts once enabled
  assign req_counts = req_sel.hit && ((req_sel.idx < 3'h5) || opt_sel_q[2'(req_sel.idx - 3'h5)]);

  // --------------------------------------------------------------------------
  // serial engine
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q    <= H_IDLE;
      shift_q    <= '0;
      bits_q     <= 5'h00;
      cnt_q      <= 3'h0;
      sclk_q     <= 1'b0;
      sdata_q    <= 1'b0;
      le_q       <= 1'b0;
      BUSY       <= 1'b0;
      WRITE_DONE <= 1'b0;
    end else if (CE) begin
      WRITE_DONE <= 1'b0;
      cnt_q      <= half_done ? 3'h0 : cnt_q + 3'h1;
      case (state_q)
        H_IDLE: begin
          cnt_q <= 3'h0;
          if (WRITE_REQ) begin
            shift_q <= {fixed_word[`CFG_WORD_W-2:0], 1'b0};
            sdata_q <= fixed_word[`CFG_WORD_W-1];
            bits_q  <= 5'(`CFG_WORD_W - 1);
            BUSY    <= 1'b1;
            state_q <= H_SHIFT_LO;
          end
        end
        H_SHIFT_LO: begin
          if (half_done) begin
            sclk_q  <= 1'b1;
            state_q <= H_SHIFT_HI;
          end
        end
        H_SHIFT_HI: begin
          if (half_done) begin
            sclk_q <= 1'b0;
            if (bits_q == 5'h00) begin
              le_q    <= 1'b1;
              state_q <= H_LATCH;
            end else begin
              sdata_q <= shift_q[`CFG_WORD_W-1];
              shift_q <= {shift_q[`CFG_WORD_W-2:0], 1'b0};
              bits_q  <= bits_q - 5'h01;
              state_q <= H_SHIFT_LO;
            end
          end
        end
        H_LATCH: begin
          if (half_done) begin
            le_q       <= 1'b0;
            BUSY       <= 1'b0;
            WRITE_DONE <= 1'b1;
            state_q    <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // readiness bookkeeping
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      loaded_q     <= 8'h00;
      opt_sel_q    <= 3'h0;
      CONFIG_READY <= 1'b0;
    end else if (CE) begin
      if (state_q == H_IDLE && WRITE_REQ && req_counts) begin
        loaded_q[req_sel.idx] <= 1'b1;
      end
      // clearing an access bit falls back to defaults, so earlier data no longer counts
      if (state_q == H_IDLE && WRITE_REQ && req_sel.hit && req_sel.idx == 3'h3) begin
        opt_sel_q     <= WRITE_WORD[`ACCESS_LSB+3:`ACCESS_LSB+1];
        loaded_q[7:5] <= loaded_q[7:5] & WRITE_WORD[`ACCESS_LSB+3:`ACCESS_LSB+1];
      end
      CONFIG_READY <= (&loaded_q[4:0]) && opt_ok && !BUSY;
    end
  end

  assign LINK.sclk     = sclk_q;
  assign LINK.sdata    = sdata_q;
  assign LINK.latch_en = le_q;

endmodule

`default_nettype wire

// ==== dv/synth_cfg_props.sv ====
`default_nettype none

module synth_cfg_props
(
  input wire logic                     REF_CLK,
  input wire logic                     RST_N,
  input wire logic                     sclk,
  input wire logic                     latch_en,
  input wire logic                     TEST_LOCK_PIN_O,
  input wire logic                     TEST_LOCK_PIN_OE_N,
  input wire logic                     ANA_LOCK_MAIN,
  input wire logic [3:0]               MAIN_PUMP_GAIN,
  input wire logic [4:0]               MAIN_PUMP_SCALE,
  input wire logic [3:0]               ACCESS_SELECT,
  input wire synth_cfg_pkg::cfg_word_t ACCESS_WORD,
  input wire synth_cfg_pkg::cfg_word_t MODE_WORD,
  input wire synth_cfg_pkg::cfg_word_t FRACTION_EXT_WORD,
  input wire synth_cfg_pkg::cfg_word_t FASTLOCK_WORD,
  input wire synth_cfg_pkg::cfg_word_t TEST_RESET_WORD
);
  import synth_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  pump_scale_a: assert property (MAIN_PUMP_SCALE == {1'b0, MAIN_PUMP_GAIN} + 5'h01)
    else $error("pump scale is not gain plus one");
  access_must_a: assert property (ACCESS_WORD[20] && ACCESS_SELECT[0])
    else $error("access bit 20 not set");
  frac_default_a: assert property (!ACCESS_SELECT[1] [*2] |-> FRACTION_EXT_WORD == 24'h00000B)
    else $error("word five not forced to default");
  fast_default_a: assert property (!ACCESS_SELECT[2] [*2] |-> FASTLOCK_WORD == 24'h00000D)
    else $error("word six not forced to default");
  test_default_a: assert property (!ACCESS_SELECT[3] [*2] |-> TEST_RESET_WORD == 24'h00090F)
    else $error("word seven not forced to default");
  mode_layout_a: assert property (MODE_WORD[22:18] == 5'h08 && !MODE_WORD[13] && MODE_WORD[3:0] == 4'h9)
    else $error("mode word fixed bits wrong");
  pin_hiz_a: assert property (MODE_WORD[7:4] == 4'h0 [*2] |-> TEST_LOCK_PIN_OE_N)
    else $error("pin driven in high impedance code");
  pin_high_a: assert property (MODE_WORD[7:4] == 4'h1 [*2] |-> !TEST_LOCK_PIN_OE_N && TEST_LOCK_PIN_O)
    else $error("pin not driven high");
  open_drain_a: assert property ((MODE_WORD[7:4] == 4'h7 && ANA_LOCK_MAIN) [*2] |->
    TEST_LOCK_PIN_OE_N && !TEST_LOCK_PIN_O)
    else $error("open drain pin not released when locked");
  latch_quiet_a: assert property ($rose(latch_en) |-> !sclk [*2])
    else $error("serial clock moves during latch");

  all_access_c: cover property (ACCESS_SELECT == 4'hF);
  divider_c: cover property (MODE_WORD[7:4] == 4'hF);
  latch_c: cover property ($rose(latch_en));
endmodule

`default_nettype wire

// ==== dv/tb_synth_config_register_bank.sv ====
`default_nettype none

module tb_synth_config_register_bank;
  import synth_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       req = 1'b0;
  cfg_word_t  wword = 24'h000000;
  logic [3:0] dl = 4'h0;
  logic [3:0] div = 4'h0;
  logic       busy, done, ready, pin_o, pin_oe_n, fmt_err;
  logic [3:0] gain, acc_sel;
  logic [4:0] scale, loaded;
  cfg_word_t  acc_w, mode_w, frac_w, fast_w, test_w;
  int         n_errors = 0;
  int         checks = 0;

  serial_cfg_if i_serial_cfg_if ();

  synth_cfg_host i_synth_cfg_host (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'b1), .LINK(i_serial_cfg_if),
    .WRITE_REQ(req), .WRITE_WORD(wword), .BUSY(busy), .WRITE_DONE(done), .CONFIG_READY(ready));

  // dl: digital main, digital aux, analog main, analog aux
  synth_cfg_device i_synth_cfg_device (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'b1), .LINK(i_serial_cfg_if),
    .DIG_LOCK_MAIN(dl[0]), .DIG_LOCK_AUX(dl[1]), .ANA_LOCK_MAIN(dl[2]), .ANA_LOCK_AUX(dl[3]),
    .AUX_REF_DIV(div[0]), .AUX_FB_DIV(div[1]), .MAIN_REF_DIV(div[2]), .MAIN_FB_DIV(div[3]),
    .TEST_LOCK_PIN_O(pin_o), .TEST_LOCK_PIN_OE_N(pin_oe_n), .MAIN_PUMP_GAIN(gain), .MAIN_PUMP_SCALE(scale),
    .ACCESS_SELECT(acc_sel), .ACCESS_WORD(acc_w), .MODE_WORD(mode_w), .FRACTION_EXT_WORD(frac_w),
    .FASTLOCK_WORD(fast_w), .TEST_RESET_WORD(test_w), .MANDATORY_LOADED(loaded), .FORMAT_ERROR(fmt_err));

  synth_cfg_props i_synth_cfg_props (.REF_CLK(ref_clk), .RST_N(rst_n), .sclk(i_serial_cfg_if.sclk),
    .latch_en(i_serial_cfg_if.latch_en), .TEST_LOCK_PIN_O(pin_o), .TEST_LOCK_PIN_OE_N(pin_oe_n),
    .ANA_LOCK_MAIN(dl[2]), .MAIN_PUMP_GAIN(gain), .MAIN_PUMP_SCALE(scale), .ACCESS_SELECT(acc_sel),
    .ACCESS_WORD(acc_w), .MODE_WORD(mode_w), .FRACTION_EXT_WORD(frac_w), .FASTLOCK_WORD(fast_w),
    .TEST_RESET_WORD(test_w));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one whole word through the host; waits out the device's two-edge update
  task automatic send(input cfg_word_t w);
    int k;
    k = 0;
    @(posedge ref_clk);
    #1;
    wword = w;
    req = 1'b1;
    @(posedge ref_clk);
    #1;
    req = 1'b0;
    check("busy", {23'h0, busy}, 24'h000001);
    while (done !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check("write done", {23'h0, done}, 24'h000001);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic m, input logic a);
    // digital lock main=m aux=a; analog lock swapped so a mix-up shows
    case (c)
      4'h1: return 2'b01;
      4'h2: return 2'b00;
      4'h3: return {1'b0, m & a};
      4'h4: return {1'b0, m};
      4'h5: return {1'b0, a};
      4'h6: return {a & m, 1'b0};
      4'h7: return {a, 1'b0};
      4'h8: return {m, 1'b0};
      4'h9: return {1'b0, a & m};
      4'hA: return {1'b0, a};
      4'hB: return {1'b0, m};
      default: return 2'b10;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    check("access word", acc_w, 24'h100007);
    check("mode word", mode_w, 24'h22C709);
    check("word five", frac_w, 24'h00000B);
    check("word six", fast_w, 24'h00000D);
    check("word seven", test_w, 24'h00090F);
    check("pin enable", {23'h0, pin_oe_n}, 24'h000001);
    check("ready", {23'h0, ready}, 24'h000000);
    $display("test reset done");
  endtask

  task automatic t_mandatory();
    send(24'h000000);
    check("loaded", {19'h0, loaded}, 24'h000001);
    send(24'h000003);
    send(24'h000005);
    send(24'h100007);
    check("ready early", {23'h0, ready}, 24'h000000);
    send(24'h22C709);
    check("loaded", {19'h0, loaded}, 24'h00001F);
    check("ready", {23'h0, ready}, 24'h000001);
    check("mode word", mode_w, 24'h22C709);
    $display("test mandatory done");
  endtask

  task automatic t_gain();
    for (int n = 0; n < 16; n += 5) begin
      send({4'h1, 4'(n), 12'h003, 4'h7});
      check("gain", {20'h0, gain}, 24'(n));
      check("scale", {19'h0, scale}, 24'(n + 1));
    end
    $display("test gain done");
  endtask

  task automatic t_mode();
    send(24'hA11809);
    check("mode fields", mode_w, 24'hA11809);
    check("format", {23'h0, fmt_err}, 24'h000000);
    send(24'h02C709);
    check("forced pattern", mode_w, 24'h22C709);
    check("format fixed", {23'h0, fmt_err}, 24'h000000);
    $display("test mode done");
  endtask

  task automatic t_optional();
    send(24'h12345B);
    check("ignored five", frac_w, 24'h00000B);
    send(24'h300037);
    check("ready pending", {23'h0, ready}, 24'h000000);
    send(24'h12345B);
    check("word five", frac_w, 24'h12345B);
    check("ready", {23'h0, ready}, 24'h000001);
    send(24'hABCDED);
    check("ignored six", fast_w, 24'h00000D);
    send(24'hF00037);
    send(24'h00210F);
    check("word seven", test_w, 24'h00210F);
    check("six reenabled", fast_w, 24'h00000D);
    check("five kept", frac_w, 24'h12345B);
    send(24'h100037);
    check("five back", frac_w, 24'h00000B);
    check("seven back", test_w, 24'h00090F);
    $display("test optional done");
  endtask

  task automatic t_pin();
    logic [3:0] p;
    logic       o;
    for (int c = 0; c < 12; c++) begin
      send(24'h22C709 | {16'h0, 4'(c), 4'h0});
      for (int q = 1; q < 4; q++) begin
        p = 4'(q);
        dl = {p[0], p[1], p[1], p[0]};
        repeat (3) @(posedge ref_clk);
        #1;
        check("pin", {22'h0, pin_oe_n, (c == 0) ? 1'b0 : pin_o}, {22'h0, exp_pin(4'(c), p[0], p[1])});
      end
    end
    for (int c = 12; c < 16; c++) begin
      send(24'h22C709 | {16'h0, 4'(c), 4'h0});
      o = pin_o;
      div[(c + 1) % 4] = 1'b1;
      @(posedge ref_clk);
      #1;
      div = 4'h0;
      repeat (3) @(posedge ref_clk);
      #1;
      check("other divider", {22'h0, pin_oe_n, pin_o}, {22'h0, 1'b0, o});
      div[c - 12] = 1'b1;
      @(posedge ref_clk);
      #1;
      div = 4'h0;
      repeat (3) @(posedge ref_clk);
      #1;
      check("halved divider", {23'h0, pin_o}, {23'h0, ~o});
    end
    $display("test pin done");
  endtask

  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_mandatory();
    t_gain();
    t_mode();
    t_optional();
    t_pin();
    final_report();
  end

  // 34 words at about a hundred cycles each, with margin
  initial begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    final_report();
  end
endmodule

`default_nettype wire
